// file: cec_map.vh
// Functional notes
// RQ1: result high when positive input exceeds negative
// RQ2: mux enabled, converter off: channel picks negative
// RQ3: otherwise dedicated negative pin feeds comparator
// RQ4: bandgap select replaces positive pin input
// RQ5: result synchronised, one to two cycles late
// RQ6: matching result transition sets interrupt flag
// RQ7: flag cleared by vector taken or write one
// RQ8: request needs flag, enable and global enable
// RQ9: mode: toggle, reserved, falling, rising edge
// RQ10: capture route feeds result to timer capture
// RQ11: software also enables timer capture interrupt
// RQ12: disable bit powers comparator off any time
// RQ13: software masks interrupt before changing disable
// RQ14: software masks interrupt before changing mode
// RQ15: converter enable gates converter, frees multiplexer
// RQ16: edges found by comparing with previous result
`ifndef CEC_MAP_VH
`define CEC_MAP_VH

// register byte addresses
`define CEC_ADDR_SPECIAL_IO     8'h00
`define CEC_ADDR_CTRL_STATUS    8'h04
`define CEC_ADDR_CONVERTER      8'h08

// special function io fields
`define CEC_SFIO_MUX_EN         3
`define CEC_SFIO_WMASK          8'h0F
`define CEC_SFIO_RESET          8'h00
`define CEC_SFIO_FIELD_RESET    4'h0

// control and status fields
`define CEC_CS_DISABLE          7
`define CEC_CS_BANDGAP          6
`define CEC_CS_RESULT           5
`define CEC_CS_FLAG             4
`define CEC_CS_IRQ_EN           3
`define CEC_CS_ROUTE            2
`define CEC_CS_MODE_HI          1
`define CEC_CS_MODE_LO          0
`define CEC_CS_RESET            8'h00

// converter mirror fields
`define CEC_CONV_ENABLE         7
`define CEC_CONV_CH_HI          2
`define CEC_CONV_CH_LO          0
`define CEC_CONV_RESET          8'h00

// interrupt modes
`define CEC_MODE_TOGGLE         2'h0
`define CEC_MODE_RESERVED       2'h1
`define CEC_MODE_FALLING        2'h2
`define CEC_MODE_RISING         2'h3

// negative input selector codes
`define CEC_NEG_PIN             4'h8

`endif

// file: cec_comparator.v
`timescale 1ns/1ns
`include "cec_map.vh"

module cec_comparator
(
	// clock and reset
	input  wire        i_mclk,
	input  wire        i_resetn,
	// ahb-lite slave
	input  wire        i_hsel,
	input  wire [31:0] i_haddr,
	input  wire [1:0]  i_htrans,
	input  wire        i_hwrite,
	input  wire [2:0]  i_hsize,
	input  wire [31:0] i_hwdata,
	input  wire        i_hready,
	output wire        o_hreadyout,
	output wire        o_hresp,
	output reg  [31:0] o_hrdata,
	// analog comparator front end
	input  wire        i_raw_compare,
	output wire        o_comparator_power_down,
	output wire        o_positive_bandgap,
	output wire [3:0]  o_negative_select,
	// converter
	output wire        o_converter_enable,
	// cpu interrupt side
	input  wire        i_global_irq_enable,
	input  wire        i_irq_vector_taken,
	output wire        o_irq,
	// timer input capture front end
	output wire        o_capture_input,
	output wire        o_comparator_result
);

	// registers
	reg  [3:0]  special_io;
	reg         comparator_disable;
	reg         bandgap_select;
	reg         comparator_irq_flag;
	reg         comparator_irq_enable;
	reg         capture_route_enable;
	reg  [1:0]  irq_mode;
	reg         converter_enable;
	reg  [2:0]  channel_select;

	// synchroniser and edge history
	reg         sync_stage1;
	reg         comparator_result;
	reg         result_prev;

	// ahb data phase
	reg         dp_write;
	reg  [7:0]  dp_addr;

	wire        negative_mux_enable;
	wire        addr_phase;
	wire        wr_special;
	wire        wr_status;
	wire        wr_converter;
	wire [7:0]  wbyte;
	wire        rise_event;
	wire        fall_event;
	reg         trigger_event;
	reg         next_flag;
	reg  [7:0]  next_rdata;
	reg  [3:0]  next_special_io;
	reg         next_disable;
	reg         next_bandgap;
	reg         next_irq_enable;
	reg         next_route;
	reg  [1:0]  next_irq_mode;
	reg         next_conv_enable;
	reg  [2:0]  next_channel;
	reg         next_dp_write;
	reg  [7:0]  next_dp_addr;
	reg  [31:0] next_hrdata;
	reg         next_stage1;
	reg         next_result;
	reg         next_prev;

	assign negative_mux_enable = special_io[`CEC_SFIO_MUX_EN];
	assign addr_phase  = i_hsel & i_htrans[1] & i_hready;
	assign wbyte       = i_hwdata[7:0];
	assign wr_special  = dp_write & (dp_addr == `CEC_ADDR_SPECIAL_IO);
	assign wr_status   = dp_write & (dp_addr == `CEC_ADDR_CTRL_STATUS);
	assign wr_converter = dp_write & (dp_addr == `CEC_ADDR_CONVERTER);

	// always ready, always okay
	assign o_hreadyout = 1'b1;
	assign o_hresp     = 1'b0;

	// ahb address phase capture and read data
	always @*
	begin
		next_dp_write = addr_phase & i_hwrite;
		next_dp_addr  = {i_haddr[7:2], 2'b00};
		next_hrdata   = o_hrdata;
		if (addr_phase & !i_hwrite)
		begin
			next_hrdata = {24'h000000, next_rdata};
		end
	end

	always @(posedge i_mclk)
	begin
		if (!i_resetn)
		begin
			dp_write <= 1'b0;
			dp_addr  <= 8'h00;
			o_hrdata <= 32'h00000000;
		end
		else
		begin
			dp_write <= next_dp_write;
			dp_addr  <= next_dp_addr;
			o_hrdata <= next_hrdata;
		end
	end

	// read mux, unmapped reads zero
	always @*
	begin
		next_rdata = 8'h00;
		case ({i_haddr[7:2], 2'b00})
			`CEC_ADDR_SPECIAL_IO:
				next_rdata = {4'h0, special_io};
			`CEC_ADDR_CTRL_STATUS:
			begin
				next_rdata[`CEC_CS_DISABLE] = comparator_disable;
				next_rdata[`CEC_CS_BANDGAP] = bandgap_select;
				next_rdata[`CEC_CS_RESULT]  = comparator_result;
				next_rdata[`CEC_CS_FLAG]    = comparator_irq_flag;
				next_rdata[`CEC_CS_IRQ_EN]  = comparator_irq_enable;
				next_rdata[`CEC_CS_ROUTE]   = capture_route_enable;
				next_rdata[`CEC_CS_MODE_HI:`CEC_CS_MODE_LO] = irq_mode;
			end
			`CEC_ADDR_CONVERTER:
			begin
				next_rdata[`CEC_CONV_ENABLE] = converter_enable;
				next_rdata[`CEC_CONV_CH_HI:`CEC_CONV_CH_LO] = channel_select;
			end
			default:
				next_rdata = 8'h00;
		endcase
	end

	// next values of the software-written control bits
	always @*
	begin
		next_special_io  = special_io;
		next_disable     = comparator_disable;
		next_bandgap     = bandgap_select;
		next_irq_enable  = comparator_irq_enable;
		next_route       = capture_route_enable;
		next_irq_mode    = irq_mode;
		next_conv_enable = converter_enable;
		next_channel     = channel_select;
		if (wr_special)
		begin
			next_special_io = wbyte[3:0];
		end
		if (wr_status)
		begin
			next_disable    = wbyte[`CEC_CS_DISABLE]; // see RQ12
			next_bandgap    = wbyte[`CEC_CS_BANDGAP];
			next_irq_enable = wbyte[`CEC_CS_IRQ_EN];
			next_route      = wbyte[`CEC_CS_ROUTE];
			next_irq_mode   = wbyte[`CEC_CS_MODE_HI:`CEC_CS_MODE_LO];
		end
		if (wr_converter)
		begin
			next_conv_enable = wbyte[`CEC_CONV_ENABLE];
			next_channel     = wbyte[`CEC_CONV_CH_HI:`CEC_CONV_CH_LO];
		end
	end

	always @(posedge i_mclk)
	begin
		if (!i_resetn)
		begin
			special_io            <= `CEC_SFIO_FIELD_RESET;
			comparator_disable    <= 1'b0;
			bandgap_select        <= 1'b0;
			comparator_irq_enable <= 1'b0;
			capture_route_enable  <= 1'b0;
			irq_mode              <= `CEC_MODE_TOGGLE;
			converter_enable      <= 1'b0;
			channel_select        <= 3'h0;
		end
		else
		begin
			special_io            <= next_special_io;
			comparator_disable    <= next_disable;
			bandgap_select        <= next_bandgap;
			comparator_irq_enable <= next_irq_enable;
			capture_route_enable  <= next_route;
			irq_mode              <= next_irq_mode;
			converter_enable      <= next_conv_enable;
			channel_select        <= next_channel;
		end
	end

	// input selection for the analog comparator
	assign o_comparator_power_down = comparator_disable; // see RQ12
	assign o_positive_bandgap      = bandgap_select; // see RQ4
	assign o_converter_enable      = converter_enable; // see RQ15
	// see RQ2 RQ3 RQ15
	assign o_negative_select = (negative_mux_enable & !converter_enable) ?
		{1'b0, channel_select} : `CEC_NEG_PIN;

	// synchroniser stages and edge history
	always @*
	begin
		next_stage1 = i_raw_compare; // see RQ1 RQ5
		next_result = sync_stage1; // see RQ5
		next_prev   = comparator_result; // see RQ16
	end

	// two-flop synchroniser on the comparator output
	always @(posedge i_mclk)
	begin
		if (!i_resetn)
		begin
			sync_stage1       <= 1'b0;
			comparator_result <= 1'b0;
			result_prev       <= 1'b0;
		end
		else
		begin
			sync_stage1       <= next_stage1;
			comparator_result <= next_result;
			result_prev       <= next_prev;
		end
	end

	assign rise_event = comparator_result & !result_prev; // see RQ16
	assign fall_event = !comparator_result & result_prev; // see RQ16

	// event selection by mode
	always @*
	begin
		case (irq_mode)
			`CEC_MODE_TOGGLE: // see RQ9
			begin
				trigger_event = rise_event | fall_event;
			end
			`CEC_MODE_FALLING: // see RQ9
			begin
				trigger_event = fall_event;
			end
			`CEC_MODE_RISING: // see RQ9
			begin
				trigger_event = rise_event;
			end
			`CEC_MODE_RESERVED: // see RQ9
			begin
				trigger_event = 1'b0;
			end
			default:
			begin
				trigger_event = 1'b0;
			end
		endcase
	end

	// flag: set beats clear
	always @*
	begin
		next_flag = comparator_irq_flag;
		if (i_irq_vector_taken)
			next_flag = 1'b0; // see RQ7
		if (wr_status & wbyte[`CEC_CS_FLAG])
			next_flag = 1'b0; // see RQ7
		if (trigger_event)
			next_flag = 1'b1; // see RQ6
	end

	always @(posedge i_mclk)
	begin
		if (!i_resetn)
		begin
			comparator_irq_flag <= 1'b0;
		end
		else
		begin
			comparator_irq_flag <= next_flag;
		end
	end

	// see RQ8
	assign o_irq = comparator_irq_flag & comparator_irq_enable &
		i_global_irq_enable;
	assign o_capture_input = capture_route_enable & comparator_result; // see RQ10
	assign o_comparator_result = comparator_result;

endmodule // cec_comparator

// file: cec_comparator_sva.sv
`timescale 1ns/1ns
`include "cec_map.vh"
module cec_comparator_sva
(
	// clock and reset
	input wire       i_mclk,
	input wire       i_resetn,
	// watched signals
	input wire       i_raw_compare,
	input wire       i_global_irq_enable,
	input wire       i_irq_vector_taken,
	input wire       o_hreadyout,
	input wire       o_hresp,
	input wire [3:0] o_negative_select,
	input wire       o_converter_enable,
	input wire       o_irq,
	input wire       o_capture_input,
	input wire       o_comparator_result
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);
	property p_sync;
		$past(i_resetn) && $past(i_resetn, 2) |->
			o_comparator_result == $past(i_raw_compare, 2);
	endproperty
	property p_hold;
		$past(i_resetn) ##0 $stable(i_raw_compare)[*3] |->
			$stable(o_comparator_result);
	endproperty
	property p_vec;
		i_irq_vector_taken && $stable(o_comparator_result) |=> !o_irq;
	endproperty
	property p_gate;
		o_irq |-> i_global_irq_enable;
	endproperty
	property p_cap;
		o_capture_input |-> o_comparator_result;
	endproperty
	property p_neg_pin;
		o_converter_enable |-> o_negative_select == `CEC_NEG_PIN;
	endproperty
	property p_neg_range;
		o_negative_select <= `CEC_NEG_PIN;
	endproperty
	property p_ready;
		o_hreadyout && !o_hresp;
	endproperty
	a_sync: assert property (p_sync) else $error("sync delay");
	a_hold: assert property (p_hold) else $error("result moved");
	a_vec: assert property (p_vec) else $error("vector no clear");
	a_gate: assert property (p_gate) else $error("irq ungated");
	a_cap: assert property (p_cap) else $error("capture wrong");
	a_neg_pin: assert property (p_neg_pin) else $error("neg pin");
	a_neg_range: assert property (p_neg_range) else $error("neg code");
	a_ready: assert property (p_ready) else $error("bus stall");
	c_irq: cover property ($rose(o_irq));
	c_cap: cover property (o_capture_input);
	c_ch7: cover property (o_negative_select == 4'h7);
endmodule // cec_comparator_sva

bind cec_comparator cec_comparator_sva i_sva (.i_mclk, .i_resetn,
	.i_raw_compare, .i_global_irq_enable, .i_irq_vector_taken, .o_hreadyout,
	.o_hresp, .o_negative_select, .o_converter_enable, .o_irq,
	.o_capture_input, .o_comparator_result);

// file: cec_analog_model.sv
`timescale 1ns/1ns
`include "cec_map.vh"
module cec_analog_model
#(
	parameter [7:0] NEG_PIN_LEVEL = 8'h64
)
(
	// levels from the bench
	input  wire [7:0] i_vpos,
	input  wire [7:0] i_vbg,
	// selections from the block
	input  wire       i_bandgap,
	input  wire [3:0] i_neg_sel,
	// raw decision
	output wire       o_raw
);
	wire [7:0] plus  = i_bandgap ? i_vbg : i_vpos;
	// channel n sits at n times 0x14
	wire [7:0] minus = (i_neg_sel == `CEC_NEG_PIN) ? NEG_PIN_LEVEL :
		{5'h00, i_neg_sel[2:0]} * 8'h14;
	assign o_raw = plus > minus;
endmodule // cec_analog_model

// file: cec_comparator_test.sv
`timescale 1ns/1ns
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_count++; \
$display("FAIL %0t %h %h", $time, (a), (e)); end end
module cec_comparator_test;
	logic        i_mclk = 0;
	logic        i_resetn = 0;
	logic        i_hsel = 1;
	logic [31:0] i_haddr = 0;
	logic [1:0]  i_htrans = 0;
	logic        i_hwrite = 0;
	logic [2:0]  i_hsize = 3'h2;
	logic [31:0] i_hwdata = 0;
	logic        i_global_irq_enable = 0;
	logic        i_irq_vector_taken = 0;
	wire         i_hready, o_hreadyout, o_hresp, i_raw_compare, o_irq;
	wire [31:0]  o_hrdata;
	wire [3:0]   o_negative_select;
	wire         o_comparator_power_down, o_positive_bandgap;
	wire         o_converter_enable, o_capture_input, o_comparator_result;
	logic [7:0]  vpos = 8'h46;
	logic [31:0] q;
	int          err_count = 0;
	int          n_checks = 0;
	assign i_hready = o_hreadyout;
	always #5 i_mclk = ~i_mclk;
	cec_comparator i_dut (.*);
	cec_analog_model i_ana (.i_vpos(vpos), .i_vbg(8'h96),
		.i_bandgap(o_positive_bandgap), .i_neg_sel(o_negative_select),
		.o_raw(i_raw_compare));
	task results;
		if (err_count == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task ready;
		int n;
		n = 0;
		@(posedge i_mclk);
		while (o_hreadyout !== 1'b1 && n < 20)
		begin
			@(posedge i_mclk);
			n++;
		end
		if (n >= 20)
		begin
			err_count++;
			results;
		end
	endtask
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		i_htrans <= 2'h2;
		i_haddr <= a;
		i_hwrite <= w;
		ready;
		i_htrans <= 2'h0;
		i_hwdata <= d;
		ready;
		q = o_hrdata;
		@(negedge i_mclk);
	endtask
	task t_regs;
		bus(0, 32'h00, 0);
		`CHK(q, 32'h00000000)
		bus(0, 32'h04, 0);
		`CHK(q & 32'hDF, 32'h00000000)
		bus(1, 32'h00, 32'hFF);
		bus(0, 32'h00, 0);
		`CHK(q, 32'h0000000F)
		bus(0, 32'h40, 0);
		`CHK(q, 32'h00000000)
	endtask
	task t_mux;
		bus(1, 32'h00, 32'h08);
		for (int c = 0; c < 8; c++)
		begin
			bus(1, 32'h08, c);
			repeat (3) @(negedge i_mclk);
			`CHK(o_negative_select, c[3:0])
			`CHK(o_comparator_result, c < 4)
		end
		bus(1, 32'h08, 32'h85);
		`CHK(o_negative_select, 4'h8)
		`CHK(o_converter_enable, 1'b1)
		bus(1, 32'h00, 0);
	endtask
	task t_modes;
		@(posedge i_mclk);
		vpos <= 8'h00;
		i_global_irq_enable <= 1;
		for (int m = 0; m < 4; m++)
		begin
			bus(1, 32'h04, m);
			bus(1, 32'h04, 32'h18 | m);
			@(posedge i_mclk);
			vpos <= 8'hC8;
			repeat (4) @(negedge i_mclk);
			`CHK(o_irq, m == 0 || m == 3)
			@(posedge i_mclk);
			i_global_irq_enable <= 0;
			@(negedge i_mclk);
			`CHK(o_irq, 1'b0)
			@(posedge i_mclk);
			i_global_irq_enable <= 1;
			bus(1, 32'h04, 32'h18 | m);
			`CHK(o_irq, 1'b0)
			@(posedge i_mclk);
			vpos <= 8'h00;
			repeat (4) @(negedge i_mclk);
			`CHK(o_irq, m == 0 || m == 2)
			@(posedge i_mclk);
			i_irq_vector_taken <= 1;
			@(posedge i_mclk);
			i_irq_vector_taken <= 0;
			@(negedge i_mclk);
			`CHK(o_irq, 1'b0)
		end
	endtask
	task t_misc;
		bus(1, 32'h04, 32'h03);
		bus(1, 32'h04, 32'hC4);
		repeat (4) @(negedge i_mclk);
		`CHK(o_positive_bandgap, 1'b1)
		`CHK(o_comparator_power_down, 1'b1)
		`CHK(o_capture_input, 1'b1)
		// timer capture mask is the timer's own
		bus(0, 32'h04, 0);
		`CHK(q, 32'h000000F4)
		bus(1, 32'h04, 32'h40);
		`CHK(o_capture_input, 1'b0)
	endtask
	initial
	begin
		repeat (6) @(posedge i_mclk);
		i_resetn <= 1;
		t_regs;
		t_mux;
		t_modes;
		t_misc;
		results;
	end
endmodule // cec_comparator_test
